/* File: src/dma_arb.sv */
// shared control of a four-channel dma: fair rotating arbiter, bus bandwidth
// throttle, request source selection, channel interrupts, channel state.
// assumes the channel sequencers, the cpu bus and the peripherals share aclk;
// only the external request pins are asynchronous.
//
// Contract
// - rotate priority; serviced channel becomes lowest
// - bandwidth code limits dma transfers per cpu op
// - bandwidth code held in cpu control register
// - one interrupt line per channel
// - interrupt on buffer end with irq flag
// - direct mode watermark interrupt on length match
// - interrupt on buffer ended by peripheral eof
// - select bits 3..0 hold writable request source
// - select bits 7..4 read-only state, reset zero
// - state codes for off and waiting eof
// - state codes for first transfer, send command
// - state codes for transfer in progress
// - state codes for close, new list; others unused
// - source zero requests continuously, memory to memory
// - sources one to three are timers
// - sources four to twelve are serial, adc
// - source fifteen is own pin, not channel 3
// - sources thirteen, fourteen never trigger
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "dma_arb_consts.svh"

module dma_arb #(
    parameter int ADDR_WIDTH = 26,
    parameter int NUM_PERIPH = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // peripheral request and end-of-frame lines, code n on bit n-1
    input wire logic [NUM_PERIPH-1:0] periph_req,
    input wire logic [NUM_PERIPH-1:0] periph_eof,
    // asynchronous external request pins
    input wire logic ext_request_ch0,
    input wire logic ext_request_ch1,
    input wire logic ext_request_ch2,
    // cpu completed one bus operation
    input wire logic cpu_op,
    // per-channel status from the sequencers
    input wire logic [3:0] ch_armed,
    input wire logic [3:0] ch_linked,
    input wire logic [11:0] ch_phase,
    input wire logic [3:0] ch_buf_done,
    input wire logic [3:0] ch_eof_close,
    input wire logic [3:0] ch_irq_on_buffer_end,
    input wire logic [63:0] ch_txln,
    input wire logic [31:0] ch_list_address_upper,
    // per-channel results
    output logic [3:0] grant,
    output logic [3:0] eof_request,
    output logic [3:0] irq
);

    // elaboration check: the map needs exactly twelve peripheral codes
    if (NUM_PERIPH != 12 || ADDR_WIDTH < 26) begin : g_bad_params
        $error("dma_arb: NUM_PERIPH must be 12 and ADDR_WIDTH at least 26");
    end

    // register file
    logic [3:0] req_source_reg [4]; // request source per channel
    logic [3:0] chan_state_reg [4]; // encoded channel state per channel
    logic [1:0] bw_limit_reg; // dma_bandwidth_limit field

    // bus handshake flops
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // datapath flops
    logic [2:0] ext_sync1_reg; // first synchroniser stage, read only by stage two
    logic [2:0] ext_sync2_reg; // synchronised external pins
    logic [1:0] last_reg; // last serviced channel
    logic [1:0] cpu_ops_reg; // cpu operations since last dma transfer
    logic [3:0] grant_reg;
    logic [3:0] eof_request_reg;
    logic [3:0] irq_reg;
    logic [3:0] wm_prev_reg; // watermark match seen last cycle

    // combinational per-channel terms
    logic [3:0] ch_request;
    logic [3:0] ch_eof_sel;
    logic [3:0] wm_match;
    logic [3:0] state_next [4];

    // decode helpers
    logic wr_fire;
    logic rd_fire;
    logic [23:0] wr_index;
    logic [23:0] rd_index;
    logic bw_ok;
    logic [3:0] grant_next;
    logic [1:0] last_next;
    logic [3:0] pin_req; // synchronised pins, padded so channel 3 reads a constant zero

    assign wr_fire = awready_reg && awvalid && wready_reg && wvalid;
    assign rd_fire = arready_reg && arvalid;
    assign wr_index = awaddr[25:2];
    assign rd_index = araddr[25:2];
    // channel 3 has no pin of its own; its slot is tied low
    assign pin_req = {1'b0, ext_sync2_reg};

    // two-flop synchroniser for the asynchronous request pins
    // pins may change at any moment, so two flops guard against metastability
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync1_reg <= 3'h0;
            ext_sync2_reg <= 3'h0;
        end else begin
            ext_sync1_reg <= {ext_request_ch2, ext_request_ch1, ext_request_ch0};
            ext_sync2_reg <= ext_sync1_reg;
        end
    end

    // per-channel source mux, state encoder and watermark compare
    for (genvar c = 0; c < 4; c++) begin : g_chan
        dma_arb_pkg::phase_type phase;
        logic [3:0] code;
        logic [15:0] txln;
        logic [7:0] lau;
        assign phase = dma_arb_pkg::phase_type'(ch_phase[3*c +: 3]);
        assign code = req_source_reg[c];
        assign txln = ch_txln[16*c +: 16];
        assign lau = ch_list_address_upper[8*c +: 8];

        // request line chosen by the source code, same map on every channel except code 15 on channel 3
        always_comb begin
            ch_request[c] = 1'b0;
            ch_eof_sel[c] = 1'b0;
            if (code == `SRC_CONTINUOUS) begin
                ch_request[c] = 1'b1; // memory to memory
            end else if (code <= `SRC_PERIPH_LAST) begin
                // timers, serial blocks and adc
                ch_request[c] = periph_req[code - 4'h1];
                ch_eof_sel[c] = periph_eof[code - 4'h1];
            end else if (code == `SRC_EXT_PIN && c < 3) begin
                ch_request[c] = pin_req[c]; // own pin
            end
            // codes 13, 14 and 15 on channel 3 stay quiet
        end

        // phase plus mode mapped to the readable state code
        always_comb begin
            case (phase)
                dma_arb_pkg::phase_off: begin
                    state_next[c] = `CS_OFF;
                end
                dma_arb_pkg::phase_wait_eof: begin
                    state_next[c] = ch_linked[c] ? `CS_LL_WAIT_EOF : `CS_DIR_WAIT_EOF;
                end
                dma_arb_pkg::phase_first: begin
                    state_next[c] = ch_linked[c] ? `CS_LL_FIRST : `CS_DIR_FIRST;
                end
                dma_arb_pkg::phase_busy: begin
                    state_next[c] = ch_linked[c] ? `CS_LL_BUSY : `CS_DIR_BUSY;
                end
                dma_arb_pkg::phase_close: begin
                    state_next[c] = ch_linked[c] ? `CS_LL_CLOSE : `CS_DIR_CLOSE;
                end
                dma_arb_pkg::phase_new_list: begin
                    // direct mode has no list fetch; shown as off
                    state_next[c] = ch_linked[c] ? `CS_LL_NEW_LIST : `CS_OFF;
                end
                default: begin
                    state_next[c] = `CS_OFF; // reserved codes never produced
                end
            endcase
        end

        // watermark: upper length byte zero, lower byte equals list byte
        assign wm_match[c] = !ch_linked[c] && phase != dma_arb_pkg::phase_off
            && txln[15:8] == 8'h00 && txln[7:0] == lau;
    end

    // bandwidth gate: code n needs n cpu operations since the last grant
    assign bw_ok = (bw_limit_reg == 2'h0) || (cpu_ops_reg >= bw_limit_reg);

    // rotating pick: search from the channel after the last serviced one
    // one pass over all four; the first eligible channel wins
    always_comb begin
        logic [1:0] idx;
        logic found;
        idx = 2'h0;
        found = 1'b0;
        grant_next = 4'h0;
        last_next = last_reg;
        for (int i = 1; i <= 4; i++) begin
            idx = last_reg + i[1:0]; // wraps modulo four
            if (!found && bw_ok && ch_armed[idx] && ch_request[idx]) begin
                found = 1'b1;
                grant_next[idx] = 1'b1;
                last_next = idx;
            end
        end
    end

    // arbiter state: last serviced starts at 3 so channel 0 leads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_reg <= 2'h3;
            grant_reg <= 4'h0;
        end else begin
            last_reg <= last_next; // serviced channel drops to lowest
            grant_reg <= grant_next;
        end
    end

    // cpu operation counter, saturating at three, reloaded by a grant with that cycle's cpu_op
    // saturation keeps a long cpu burst from wrapping back below the limit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_ops_reg <= 2'h3; // first transfer is never held back
        end else if (grant_next != 4'h0) begin
            cpu_ops_reg <= {1'b0, cpu_op}; // restart the count
        end else if (cpu_op && cpu_ops_reg != 2'h3) begin
            cpu_ops_reg <= cpu_ops_reg + 2'h1;
        end
    end

    // interrupt pulses and routed end-of-frame requests
    // watermark fires once on the rising match, not every cycle it holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 4'h0;
            wm_prev_reg <= 4'h0;
            eof_request_reg <= 4'h0;
        end else begin
            wm_prev_reg <= wm_match;
            eof_request_reg <= ch_eof_sel;
            // separate line per channel
            irq_reg <= (ch_buf_done & ch_irq_on_buffer_end)
                | (wm_match & ~wm_prev_reg)
                | ch_eof_close;
        end
    end

    // channel state capture, read-only to software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int c = 0; c < 4; c++) begin
                chan_state_reg[c] <= 4'(`SEL_RESET >> `CHAN_STATE_LSB);
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                chan_state_reg[c] <= state_next[c];
            end
        end
    end

    // write handshake: take address and data together, then respond
    // readies wait for both valids so address and data always pair up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (wr_fire) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            if (wr_index >= `SEL_INDEX_CH0 && wr_index <= `CPU_CTL_INDEX) begin
                bresp_reg <= `RESP_OKAY;
            end else begin
                bresp_reg <= `RESP_DECERR; // unmapped address
            end
        end else if (bvalid_reg) begin
            if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end else if (awvalid && wvalid && !awready_reg) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
        end
    end

    // register writes; the state field ignores writes
    // only byte lane 0 carries register bits; other lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int c = 0; c < 4; c++) begin
                req_source_reg[c] <= 4'(`SEL_RESET & 8'h0f);
            end
            bw_limit_reg <= `BW_RESET;
        end else if (wr_fire && wstrb[0]) begin
            for (int c = 0; c < 4; c++) begin
                if (wr_index == `SEL_INDEX_CH0 + c[23:0]) begin
                    req_source_reg[c] <= wdata[`REQ_SRC_MSB:`REQ_SRC_LSB];
                end
            end
            if (wr_index == `CPU_CTL_INDEX) begin
                bw_limit_reg <= wdata[`BW_MSB:`BW_LSB];
            end
        end
    end

    // read handshake and data mux
    // one read in flight; arready stays low while data waits for rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OKAY;
        end else if (rd_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_DECERR;
            for (int c = 0; c < 4; c++) begin
                if (rd_index == `SEL_INDEX_CH0 + c[23:0]) begin
                    // state above, source below
                    rdata_reg <= {24'h0, chan_state_reg[c], req_source_reg[c]};
                    rresp_reg <= `RESP_OKAY;
                end
            end
            if (rd_index == `CPU_CTL_INDEX) begin
                rdata_reg <= {30'h0, bw_limit_reg};
                rresp_reg <= `RESP_OKAY;
            end
        end else if (rvalid_reg) begin
            if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end else if (arvalid && !arready_reg) begin
            arready_reg <= 1'b1;
        end
    end

    // outputs straight from flops
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign grant = grant_reg;
    assign eof_request = eof_request_reg;
    assign irq = irq_reg;

endmodule

/* File: src/dma_arb_consts.svh */
// register offsets, field positions, reset values and codes of the shared
// dma channel control block; assumes 32-bit axi4-lite data, word per register
`ifndef DMA_ARB_CONSTS_SVH
`define DMA_ARB_CONSTS_SVH

// register indices; byte address is four times the index
`define SEL_INDEX_CH0 24'hffe400
`define SEL_INDEX_CH1 24'hffe401
`define SEL_INDEX_CH2 24'hffe402
`define SEL_INDEX_CH3 24'hffe403
`define CPU_CTL_INDEX 24'hffe404

// channel_request_select fields
`define REQ_SRC_LSB 0
`define REQ_SRC_MSB 3
`define CHAN_STATE_LSB 4
`define CHAN_STATE_MSB 7
`define SEL_RESET 8'h00

// cpu_control_register fields
`define BW_LSB 0
`define BW_MSB 1
`define BW_RESET 2'h0

// request source codes
`define SRC_CONTINUOUS 4'h0
`define SRC_PERIPH_LAST 4'hc
`define SRC_EXT_PIN 4'hf

// channel state codes
`define CS_OFF 4'h0
`define CS_DIR_WAIT_EOF 4'h1
`define CS_LL_WAIT_EOF 4'h2
`define CS_DIR_FIRST 4'h4
`define CS_LL_FIRST 4'h5
`define CS_DIR_BUSY 4'h6
`define CS_LL_BUSY 4'h7
`define CS_DIR_CLOSE 4'h8
`define CS_LL_NEW_LIST 4'h9
`define CS_LL_CLOSE 4'ha

// axi responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* File: src/dma_arb_pkg.sv */
// types used by the dma channel control block
// assumes the sequencer reports each channel phase with this encoding
package dma_arb_pkg;

    // sequencing phase of one channel as reported by its sequencer
    typedef enum logic [2:0] {
        phase_off,
        phase_wait_eof,
        phase_first,
        phase_busy,
        phase_close,
        phase_new_list
    } phase_type;

endpackage

/* File: verification/dma_arb_checker.sv */
// port checks of the dma channel control block
// bound to dma_arb; reads its ports only, one clock domain
`timescale 1ns/100ps
module dma_arb_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [3:0] ch_armed,
    input wire logic [3:0] ch_buf_done,
    input wire logic [3:0] ch_eof_close,
    input wire logic [3:0] ch_irq_on_buffer_end,
    input wire logic [3:0] grant,
    input wire logic [3:0] irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // buffer end on a channel whose irq flag is set
    wire logic [3:0] end_cause = ch_buf_done & ch_irq_on_buffer_end;
    property p_grant_onehot; $onehot0(grant); endproperty
    a_grant_onehot: assert property (p_grant_onehot) else $error("grant not one-hot");
    property p_grant_armed; (|grant) |-> (grant & ~$past(ch_armed)) == 4'h0; endproperty
    a_grant_armed: assert property (p_grant_armed) else $error("grant to idle channel");
    property p_irq_end;
        (|end_cause) |=> (irq & $past(end_cause)) == $past(end_cause);
    endproperty
    a_irq_end: assert property (p_irq_end) else $error("no irq on buffer end");
    property p_irq_eof;
        (|ch_eof_close) |=> (irq & $past(ch_eof_close)) == $past(ch_eof_close);
    endproperty
    a_irq_eof: assert property (p_irq_eof) else $error("no irq on early close");
    property p_wr_pair; awready |-> wready; endproperty
    a_wr_pair: assert property (p_wr_pair) else $error("write readies apart");
    property p_b_follow; awready |=> bvalid; endproperty
    a_b_follow: assert property (p_b_follow) else $error("late write response");
    property p_b_hold; bvalid && !bready |=> bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_wr_busy; bvalid |-> !awready; endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
    property p_r_follow; arready |=> rvalid; endproperty
    a_r_follow: assert property (p_r_follow) else $error("late read data");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    c_rotate: cover property (grant == 4'h1 ##1 grant == 4'h2);
    c_irq: cover property (|irq);
    c_write: cover property (bvalid && bready);
endmodule

bind dma_arb dma_arb_checker chk (
    .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .ch_armed(ch_armed), .ch_buf_done(ch_buf_done),
    .ch_eof_close(ch_eof_close), .ch_irq_on_buffer_end(ch_irq_on_buffer_end),
    .grant(grant), .irq(irq)
);

/* File: verification/periph_model.sv */
// behavioural peripherals: request, end-of-frame and external pin lines
// follow the bench's wishes on aclk; slow adds one cycle of lag
`timescale 1ns/100ps
module periph_model (
    input wire logic aclk,
    input wire logic slow,
    input wire logic [11:0] req_want,
    input wire logic [11:0] eof_want,
    input wire logic [2:0] pin_want,
    output logic [11:0] periph_req,
    output logic [11:0] periph_eof,
    output logic [2:0] pins
);
    logic [26:0] stage_reg; // wishes one cycle late
    // first stage of the slow path
    always_ff @(posedge aclk) begin
        stage_reg <= {req_want, eof_want, pin_want};
    end
    // output stage: the wishes directly, or the staged copy when slow is set
    always_ff @(posedge aclk) begin
        {periph_req, periph_eof, pins} <= slow ? stage_reg : {req_want, eof_want, pin_want};
    end
endmodule

/* File: verification/testbench.sv */
// self-checking bench of the dma channel control block
// axi4-lite master tasks, peripheral model on the request side
`timescale 1ns/100ps
`include "dma_arb_consts.svh"
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, cpu_op = 1'b0, slow = 1'b0;
    logic [25:0] awaddr = 26'h0, araddr = 26'h0;
    logic [31:0] wdata = 32'h0, ch_list_address_upper = 32'h0;
    logic [3:0] wstrb = 4'hf, ch_armed = 4'h0, ch_linked = 4'h0, ch_buf_done = 4'h0;
    logic [3:0] ch_eof_close = 4'h0, ch_irq_on_buffer_end = 4'h0, ir, gl [8];
    logic [11:0] ch_phase = 12'h0, req_want = 12'h0, eof_want = 12'h0;
    logic [11:0] periph_req, periph_eof;
    logic [2:0] pin_want = 3'h0, pins;
    logic [63:0] ch_txln = {64{1'b1}};
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] grant, eof_request, irq;
    int fail_count = 0, samples_checked = 0, gn = 0;
    logic [3:0] src_seen [4] = '{default: 4'h0}; // source code written per channel
    dma_arb uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .periph_req(periph_req), .periph_eof(periph_eof), .ext_request_ch0(pins[0]),
        .ext_request_ch1(pins[1]), .ext_request_ch2(pins[2]), .cpu_op(cpu_op),
        .ch_armed(ch_armed), .ch_linked(ch_linked), .ch_phase(ch_phase),
        .ch_buf_done(ch_buf_done), .ch_eof_close(ch_eof_close),
        .ch_irq_on_buffer_end(ch_irq_on_buffer_end), .ch_txln(ch_txln),
        .ch_list_address_upper(ch_list_address_upper), .grant(grant),
        .eof_request(eof_request), .irq(irq));
    periph_model far (.aclk(aclk), .slow(slow), .req_want(req_want), .eof_want(eof_want),
        .pin_want(pin_want), .periph_req(periph_req), .periph_eof(periph_eof), .pins(pins));
    always #5 aclk = ~aclk;
    // grant log and irq collector, sampled mid-cycle
    always @(negedge aclk) begin
        if (grant !== 4'h0) begin
            if (gn < 8) gl[gn] = grant;
            gn++;
        end
        ir = ir | irq;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // eof line each channel should route: codes 1..12 pick a peripheral, others none
    function automatic logic [3:0] eof_exp(input logic [11:0] w);
        eof_exp = 4'h0;
        for (int j = 0; j < 4; j++) begin
            if (src_seen[j] != 4'h0 && src_seen[j] <= 4'hc) begin
                eof_exp[j] = w[src_seen[j] - 4'h1];
            end
        end
    endfunction
    // one clock of a bounded wait
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 60) begin
            chk(n, 0);
            end_sim;
        end
    endtask
    task automatic wr(input logic [23:0] idx, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do tick(n); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        // response is left waiting one cycle before it is taken
        do tick(n); while (bvalid !== 1'b1);
        bready <= 1'b1;
        tick(n);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [23:0] idx, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        // read data is left waiting one cycle before it is taken
        do tick(n); while (rvalid !== 1'b1);
        rready <= 1'b1;
        tick(n);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(rresp, er);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 5; i++) rd(`SEL_INDEX_CH0 + 24'(i), 32'h0, 2'h0);
        wr(`SEL_INDEX_CH0, 32'hff, 2'h0);
        rd(`SEL_INDEX_CH0, 32'h0f, 2'h0);
        wr(`SEL_INDEX_CH0, 32'h0, 2'h0);
        rd(`CPU_CTL_INDEX + 24'h1, 32'h0, 2'h3);
        wr(`CPU_CTL_INDEX + 24'h1, 32'h3, 2'h3);
        $display("test regs done");
    endtask
    task automatic t_rotate;
        gn = 0;
        ch_armed <= 4'hf;
        repeat (8) @(posedge aclk);
        ch_armed <= 4'h0;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) chk(gl[i], 4'h1 << i);
        $display("test rotate done");
    endtask
    task automatic t_bw;
        for (int m = 0; m < 4; m++) begin
            wr(`CPU_CTL_INDEX, 32'(m), 2'h0);
            ch_armed <= 4'h1;
            repeat (8) @(posedge aclk);
            gn = 0;
            repeat (6) @(posedge aclk);
            chk(gn, m == 0 ? 6 : 0);
            for (int k = 1; k <= m; k++) begin
                cpu_op <= 1'b1;
                @(posedge aclk);
                cpu_op <= 1'b0;
                repeat (3) @(posedge aclk);
                chk(gn, k == m);
            end
            ch_armed <= 4'h0;
        end
        wr(`CPU_CTL_INDEX, 32'h0, 2'h0);
        $display("test bandwidth done");
    endtask
    task automatic t_state;
        logic [3:0] e;
        for (int l = 0; l < 2; l++) for (int p = 0; p < 6; p++) begin
            ch_linked <= {4{l[0]}};
            ch_phase <= {4{3'(p)}};
            case (p)
                0: e = 4'h0;
                1: e = 4'h1 + 4'(l);
                2: e = 4'h4 + 4'(l);
                3: e = 4'h6 + 4'(l);
                4: e = l ? 4'ha : 4'h8;
                default: e = l ? 4'h9 : 4'h0;
            endcase
            rd(`SEL_INDEX_CH0 + 24'(p % 4), {24'h0, e, 4'h0}, 2'h0);
        end
        $display("test state done");
    endtask
    task automatic ev(input logic [3:0] d, input logic [3:0] f, input logic [3:0] e);
        ir = 4'h0;
        ch_buf_done <= d;
        ch_eof_close <= f;
        @(posedge aclk);
        ch_buf_done <= 4'h0;
        ch_eof_close <= 4'h0;
        repeat (3) @(posedge aclk);
        chk(ir, e);
    endtask
    task automatic t_irq;
        logic [3:0] b;
        for (int c = 0; c < 4; c++) begin
            b = 4'(1 << c);
            ch_irq_on_buffer_end <= ~b;
            ev(b, 4'h0, 4'h0);
            ch_irq_on_buffer_end <= b;
            ev(b, 4'h0, b);
            ev(4'h0, b, b);
            ch_linked <= 4'hf;
            ch_phase <= 12'(3 << (3 * c));
            ch_txln[16*c +: 16] <= 16'h005a;
            ch_list_address_upper[8*c +: 8] <= 8'h5a;
            ev(4'h0, 4'h0, 4'h0);
            ch_linked <= 4'h0;
            ev(4'h0, 4'h0, b);
            ch_txln <= {64{1'b1}};
            ch_phase <= 12'h0;
        end
        $display("test irq done");
    endtask
    task automatic t_src;
        logic [3:0] code;
        int c;
        logic hit;
        logic [11:0] m;
        for (int k = 1; k <= 18; k++) begin
            code = k > 15 ? 4'hf : 4'(k);
            c = k % 4;
            m = code <= 4'hc ? 12'(1 << (k - 1)) : 12'h0;
            hit = code <= 4'hc || (code == 4'hf && c != 3);
            src_seen[c] = code;
            slow <= k[0];
            wr(`SEL_INDEX_CH0 + 24'(c), 32'(code), 2'h0);
            ch_armed <= 4'(1 << c);
            req_want <= ~m;
            eof_want <= ~m;
            pin_want <= hit ? ~3'(1 << c) : 3'h7;
            gn = 0;
            repeat (7) @(posedge aclk);
            chk(gn, 0);
            chk(eof_request, eof_exp(~m));
            req_want <= m;
            eof_want <= m;
            pin_want <= code == 4'hf ? 3'(1 << c) : 3'h0;
            gn = 0;
            repeat (7) @(posedge aclk);
            chk(gn > 0, hit);
            chk(eof_request, eof_exp(m));
            ch_armed <= 4'h0;
        end
        $display("test source done");
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_rotate;
        t_bw;
        t_state;
        t_irq;
        t_src;
        end_sim;
    end
endmodule
